// ### hdl/dqpc_pkg.sv
// constants, register map and mode encoding of the dual quadrature pulse counter
package dqpc_pkg;

  localparam int NUM_CNT = 2;
  localparam int CNT_W   = 32;
  localparam int WB_AW   = 32;
  localparam int WB_DW   = 32;

  // register byte addresses
  localparam logic [WB_AW-1:0] ADR_C1_CAP_RISE = 32'h2040_0204;
  localparam logic [WB_AW-1:0] ADR_C1_CAP_FALL = 32'h2040_0208;
  localparam logic [WB_AW-1:0] ADR_C1_STATUS   = 32'h2040_020C;
  localparam logic [WB_AW-1:0] ADR_C2_CAP_RISE = 32'h2040_0214;
  localparam logic [WB_AW-1:0] ADR_C2_CAP_FALL = 32'h2040_0218;
  localparam logic [WB_AW-1:0] ADR_C2_STATUS   = 32'h2040_021C;
  localparam logic [WB_AW-1:0] ADR_RUN_CTRL    = 32'h2040_0300;
  localparam logic [WB_AW-1:0] ADR_ZERO_CMD    = 32'h2040_0310;
  localparam logic [WB_AW-1:0] ADR_CAPTURE_CMD = 32'h2040_0320;
  localparam logic [WB_AW-1:0] ADR_INPUT_ROLE  = 32'h2040_0330;
  localparam logic [WB_AW-1:0] ADR_CLK_SOURCE  = 32'h2040_0340;
  localparam logic [WB_AW-1:0] ADR_SUBMODE     = 32'h2040_0350;
  localparam logic [WB_AW-1:0] ADR_ZERO_GATE   = 32'h2040_0360;

  // status register field positions
  localparam int ST_ENABLED_BIT = 0;
  localparam int ST_DIR_UP_BIT  = 1;
  localparam int ST_INPUT_BIT   = 2;

  // reset values, one bit per counter; RST_COUNT is the 32-bit count value
  localparam logic [NUM_CNT-1:0] RST_RUN       = 2'h0;
  localparam logic [NUM_CNT-1:0] RST_ROLE      = 2'h0;
  localparam logic [NUM_CNT-1:0] RST_SOURCE    = 2'h0;
  localparam logic [NUM_CNT-1:0] RST_SUBMODE   = 2'h0;
  localparam logic [NUM_CNT-1:0] RST_ZERO_GATE = 2'h3;
  localparam logic [CNT_W-1:0]   RST_COUNT     = 32'h0000_0000;

  // reference clock: fractional accumulator, rates in MHz
  localparam int CLK_MHZ      = 250;
  localparam int REF_FAST_MHZ = 20;
  localparam int REF_SLOW_MHZ = 5;
  localparam int REF_PRESCALE = REF_FAST_MHZ / REF_SLOW_MHZ;
  localparam int ACC_W        = 8;
  localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(REF_FAST_MHZ);
  localparam logic [ACC_W-1:0] ACC_MOD  = ACC_W'(CLK_MHZ);
  localparam logic [1:0]       PRE_LAST = 2'(REF_PRESCALE - 1);

  typedef enum logic [1:0] {
    MODE_QUAD   = 2'b00,
    MODE_CLKDIR = 2'b01,
    MODE_REF20  = 2'b10,
    MODE_REF5   = 2'b11
  } dqpc_mode_e;

endpackage : dqpc_pkg

// ### hdl/dqpc_top.sv
// two 32-bit up/down counters with capture registers behind a classic wishbone slave
// Summary of operation
// - two independent 32-bit up/down counters, shared control registers with one bit each
// - each counter has a rise capture and a fall capture register
// - clock-and-direction: each rising clock edge steps by one, direction 1 up, 0 down
// - quadrature: every edge of A and B counts once, direction from edge order
// - role bit: 0 makes the clear/capture input clear, 1 makes it capture
// - event counting: high input level clears counter or copies it into rise capture
// - measurement counts a 20 MHz reference, or 5 MHz through a prescaler
// - measurement: input rising edge fills rise capture, falling edge fills fall capture
// - source bit: 0 external event counting, 1 internal reference measurement
// - sub-mode bit: external 0 quadrature 1 clock-direction; internal 0 20MHz 1 5MHz
// - enable register bit per counter; every write sets both counters
// - writing 1 to a zero command bit clears that counter, 0 does nothing
// - writing 1 to a capture command bit copies count into rise capture
// - each capture register reads as a full word at its own address
// - each counter has a readable status register
// - clear and capture commands self-clear; enable and mode bits hold
// - a new capture overwrites the previous captured value
//
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none

module dqpc_top (
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  input  wire logic                        ce_i,
  input  wire logic                        wb_cyc_i,
  input  wire logic                        wb_stb_i,
  input  wire logic                        wb_we_i,
  input  wire logic [dqpc_pkg::WB_AW-1:0]  wb_adr_i,
  input  wire logic [3:0]                  wb_sel_i,
  input  wire logic [dqpc_pkg::WB_DW-1:0]  wb_dat_i,
  output logic      [dqpc_pkg::WB_DW-1:0]  wb_dat_o,
  output logic                             wb_ack_o,
  input  wire logic [dqpc_pkg::NUM_CNT-1:0] a_clk_i,
  input  wire logic [dqpc_pkg::NUM_CNT-1:0] b_dir_i,
  input  wire logic [dqpc_pkg::NUM_CNT-1:0] clear_capture_input_i
);

  localparam int N = dqpc_pkg::NUM_CNT;
  localparam int W = dqpc_pkg::CNT_W;

  // quadrature step: returns {up, down}; a double change is an illegal skip and is dropped
  function automatic logic [1:0] quad_step(input logic [1:0] prv, input logic [1:0] now);
    logic [1:0] res;
    res = 2'b00;
    unique case ({prv, now})
      4'b0001, 4'b0111, 4'b1110, 4'b1000: res = 2'b10;
      4'b0010, 4'b1011, 4'b1101, 4'b0100: res = 2'b01;
      default:                            res = 2'b00;
    endcase
    return res;
  endfunction : quad_step

  function automatic logic wr_hit(input logic [dqpc_pkg::WB_AW-1:0] adr, input logic [dqpc_pkg::WB_AW-1:0] target);
    return adr == target;
  endfunction : wr_hit

  // control registers
  logic [N-1:0] run_en;
  logic [N-1:0] role;
  logic [N-1:0] source;
  logic [N-1:0] submode;
  logic [N-1:0] zero_gate;

  // counting state
  logic [W-1:0] count     [N];
  logic [W-1:0] cap_rise  [N];
  logic [W-1:0] cap_fall  [N];
  logic [N-1:0] dir_up;
  logic [N-1:0] a_prv;
  logic [N-1:0] b_prv;
  logic [N-1:0] cc_prv;

  // reference clock generation
  logic [dqpc_pkg::ACC_W-1:0] ref_acc;
  logic                       ref_tick;
  logic [1:0]                 ref_pre;
  logic [dqpc_pkg::ACC_W:0]   acc_sum;
  logic [dqpc_pkg::ACC_W:0]   acc_wrap;

  logic         req;
  logic         wr_take;
  logic [N-1:0] zero_now;
  logic [N-1:0] cap_rise_now;
  logic [N-1:0] cap_fall_now;
  logic [N-1:0] step_up;
  logic [N-1:0] step_dn;
  logic [W-1:0] next_count [N];

  assign req     = wb_cyc_i & wb_stb_i;
  // a write takes effect at the edge where the master sees ack
  assign wr_take = ce_i & req & wb_we_i & wb_ack_o & wb_sel_i[0];
  // one spare bit so that the sum cannot wrap before it meets the modulus
  assign acc_sum  = {1'b0, ref_acc} + {1'b0, dqpc_pkg::ACC_STEP};
  assign acc_wrap = acc_sum - {1'b0, dqpc_pkg::ACC_MOD};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ref_acc  <= '0;
      ref_tick <= 1'b0;
      ref_pre  <= 2'h0;
    end else if (ce_i) begin
      // 250 is not a multiple of 20, so ticks come every 12 or 13 cycles, averaging 20 MHz
      if (acc_sum >= {1'b0, dqpc_pkg::ACC_MOD}) begin
        ref_acc  <= acc_wrap[dqpc_pkg::ACC_W-1:0];
        ref_tick <= 1'b1;
      end else begin
        ref_acc  <= acc_sum[dqpc_pkg::ACC_W-1:0];
        ref_tick <= 1'b0;
      end
      if (ref_tick) begin
        ref_pre <= (ref_pre == dqpc_pkg::PRE_LAST) ? 2'h0 : ref_pre + 2'h1;
      end
    end
  end

  always_comb begin
    for (int i = 0; i < N; i++) begin
      step_up[i] = 1'b0;
      step_dn[i] = 1'b0;
      // mode from source and sub-mode bits
      unique case (dqpc_pkg::dqpc_mode_e'({source[i], submode[i]}))
        dqpc_pkg::MODE_QUAD: begin
          {step_up[i], step_dn[i]} = quad_step({a_prv[i], b_prv[i]}, {a_clk_i[i], b_dir_i[i]});
        end
        dqpc_pkg::MODE_CLKDIR: begin
          if (a_clk_i[i] && !a_prv[i]) begin
            step_up[i] = b_dir_i[i];
            step_dn[i] = !b_dir_i[i];
          end
        end
        dqpc_pkg::MODE_REF20: begin
          step_up[i] = ref_tick;
        end
        dqpc_pkg::MODE_REF5: begin
          step_up[i] = ref_tick && (ref_pre == dqpc_pkg::PRE_LAST);
        end
      endcase
      if (!run_en[i]) begin
        step_up[i] = 1'b0;
        step_dn[i] = 1'b0;
      end
      // level clear in zero role; zero command
      zero_now[i] = (!source[i] && !role[i] && zero_gate[i] && clear_capture_input_i[i])
                    || (wr_take && wr_hit(wb_adr_i, dqpc_pkg::ADR_ZERO_CMD) && wb_dat_i[i]);
      // every source of a rise capture
      cap_rise_now[i] = (!source[i] && role[i] && clear_capture_input_i[i])
                        || (source[i] && clear_capture_input_i[i] && !cc_prv[i])
                        || (wr_take && wr_hit(wb_adr_i, dqpc_pkg::ADR_CAPTURE_CMD) && wb_dat_i[i]);
      cap_fall_now[i] = source[i] && !clear_capture_input_i[i] && cc_prv[i];
      // plain modulo arithmetic wraps both ways
      if (zero_now[i]) begin
        next_count[i] = '0;
      end else if (step_up[i]) begin
        next_count[i] = count[i] + W'(1);
      end else if (step_dn[i]) begin
        next_count[i] = count[i] - W'(1);
      end else begin
        next_count[i] = count[i];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < N; i++) begin
        count[i]    <= dqpc_pkg::RST_COUNT;
        cap_rise[i] <= dqpc_pkg::RST_COUNT;
        cap_fall[i] <= dqpc_pkg::RST_COUNT;
      end
      dir_up <= '0;
      a_prv  <= '0;
      b_prv  <= '0;
      cc_prv <= '0;
    end else if (ce_i) begin
      a_prv  <= a_clk_i;
      b_prv  <= b_dir_i;
      cc_prv <= clear_capture_input_i;
      for (int i = 0; i < N; i++) begin
        count[i] <= next_count[i];
        // captures take the pre-update count and overwrite
        if (cap_rise_now[i]) begin
          cap_rise[i] <= count[i];
        end
        if (cap_fall_now[i]) begin
          cap_fall[i] <= count[i];
        end
        if (step_up[i] || step_dn[i]) begin
          dir_up[i] <= step_up[i];
        end
      end
    end
  end

  // enable and mode bits hold until rewritten
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_en    <= dqpc_pkg::RST_RUN;
      role      <= dqpc_pkg::RST_ROLE;
      source    <= dqpc_pkg::RST_SOURCE;
      submode   <= dqpc_pkg::RST_SUBMODE;
      zero_gate <= dqpc_pkg::RST_ZERO_GATE;
    end else if (wr_take) begin
      if (wr_hit(wb_adr_i, dqpc_pkg::ADR_RUN_CTRL)) begin
        run_en <= wb_dat_i[N-1:0];
      end
      if (wr_hit(wb_adr_i, dqpc_pkg::ADR_INPUT_ROLE)) begin
        role <= wb_dat_i[N-1:0];
      end
      if (wr_hit(wb_adr_i, dqpc_pkg::ADR_CLK_SOURCE)) begin
        source <= wb_dat_i[N-1:0];
      end
      if (wr_hit(wb_adr_i, dqpc_pkg::ADR_SUBMODE)) begin
        submode <= wb_dat_i[N-1:0];
      end
      if (wr_hit(wb_adr_i, dqpc_pkg::ADR_ZERO_GATE)) begin
        zero_gate <= wb_dat_i[N-1:0];
      end
    end
  end

  function automatic logic [dqpc_pkg::WB_DW-1:0] status_word(input int i);
    logic [dqpc_pkg::WB_DW-1:0] s;
    s = '0;
    s[dqpc_pkg::ST_ENABLED_BIT] = run_en[i];
    s[dqpc_pkg::ST_DIR_UP_BIT]  = dir_up[i];
    s[dqpc_pkg::ST_INPUT_BIT]   = cc_prv[i];
    return s;
  endfunction : status_word

  // wishbone slave: ack one cycle after the request, unmapped reads give zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else if (ce_i) begin
      wb_ack_o <= req && !wb_ack_o;
      if (req && !wb_ack_o) begin
        unique case (wb_adr_i)
          dqpc_pkg::ADR_C1_CAP_RISE: wb_dat_o <= cap_rise[0];
          dqpc_pkg::ADR_C1_CAP_FALL: wb_dat_o <= cap_fall[0];
          dqpc_pkg::ADR_C2_CAP_RISE: wb_dat_o <= cap_rise[1];
          dqpc_pkg::ADR_C2_CAP_FALL: wb_dat_o <= cap_fall[1];
          dqpc_pkg::ADR_C1_STATUS:   wb_dat_o <= status_word(0);
          dqpc_pkg::ADR_C2_STATUS:   wb_dat_o <= status_word(1);
          dqpc_pkg::ADR_RUN_CTRL:    wb_dat_o <= {30'h0000_0000, run_en};
          dqpc_pkg::ADR_INPUT_ROLE:  wb_dat_o <= {30'h0000_0000, role};
          dqpc_pkg::ADR_CLK_SOURCE:  wb_dat_o <= {30'h0000_0000, source};
          dqpc_pkg::ADR_SUBMODE:     wb_dat_o <= {30'h0000_0000, submode};
          dqpc_pkg::ADR_ZERO_GATE:   wb_dat_o <= {30'h0000_0000, zero_gate};
          default:                   wb_dat_o <= '0;
        endcase
      end
    end
  end

  // ---------------- assertions ----------------
  sequence wr_cmd(logic [dqpc_pkg::WB_AW-1:0] target, int bitn);
    wr_take && wr_hit(wb_adr_i, target) && wb_dat_i[bitn];
  endsequence

  sequence clkdir_rise(int k);
    ce_i && run_en[k] && !source[k] && submode[k] && a_clk_i[k] && !a_prv[k] && !zero_now[k];
  endsequence

  ref_spacing_a: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
    $past(ce_i) && ref_tick |=> !ref_tick[*8] ##1 !ref_tick[*3] ##[1:2] ref_tick)
    else $error("reference tick spacing off");

  run_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_take && wr_hit(wb_adr_i, dqpc_pkg::ADR_RUN_CTRL) |=> run_en == $past(wb_dat_i[1:0]))
    else $error("enable register not taken from write");

  // clock enable low freezes state
  ce_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !ce_i |=> $stable(wb_ack_o) && $stable(ref_acc) && $stable(run_en) && $stable(count[0]))
    else $error("state moved while clock enable low");

  cap_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && req && !wb_ack_o && !wb_we_i && wb_adr_i == dqpc_pkg::ADR_C1_CAP_FALL
    |=> wb_dat_o == $past(cap_fall[0]))
    else $error("capture read data wrong");

  cmd_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && req && !wb_ack_o && !wb_we_i && wb_adr_i == dqpc_pkg::ADR_ZERO_CMD |=> wb_dat_o == '0)
    else $error("zero command register read nonzero");

  for (genvar g = 0; g < N; g++) begin : g_chk
    zero_cmd_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_cmd(dqpc_pkg::ADR_ZERO_CMD, g) |=> count[g] == '0)
      else $error("zero command did not clear");

    capture_cmd_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_cmd(dqpc_pkg::ADR_CAPTURE_CMD, g) |=> cap_rise[g] == $past(count[g]))
      else $error("capture command missed the count");

    clkdir_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
      clkdir_rise(g) |=> count[g] == ($past(b_dir_i[g]) ? $past(count[g]) + W'(1) : $past(count[g]) - W'(1)))
      else $error("clock-direction step wrong");

    quad_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && run_en[g] && !source[g] && !submode[g] && !zero_now[g] && !a_prv[g] && !b_prv[g]
      && !a_clk_i[g] && b_dir_i[g] |=> count[g] == $past(count[g]) + W'(1))
      else $error("quadrature step wrong");

    disabled_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !run_en[g] && !zero_now[g] |=> $stable(count[g]))
      else $error("disabled counter moved");

    level_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && !source[g] && !role[g] && zero_gate[g] && clear_capture_input_i[g] |=> count[g] == '0)
      else $error("level clear failed");

    meas_fall_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && source[g] && cc_prv[g] && !clear_capture_input_i[g] |=> cap_fall[g] == $past(count[g]))
      else $error("fall capture missed");

    meas_rise_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && source[g] && !cc_prv[g] && clear_capture_input_i[g] |=> cap_rise[g] == $past(count[g]))
      else $error("rise capture missed");

    level_capture_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && !source[g] && role[g] && clear_capture_input_i[g] |=> cap_rise[g] == $past(count[g]))
      else $error("capture role missed the count");

    quad_back_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && run_en[g] && !source[g] && !submode[g] && !zero_now[g] && !a_prv[g] && !b_prv[g]
      && a_clk_i[g] && !b_dir_i[g] |=> count[g] == $past(count[g]) - W'(1))
      else $error("quadrature reverse step wrong");

    // slow reference skips three ticks of four
    ref_slow_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && run_en[g] && source[g] && submode[g] && ref_tick && ref_pre != dqpc_pkg::PRE_LAST
      && !zero_now[g] |=> $stable(count[g]))
      else $error("slow reference stepped too often");

    wrap_down_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && run_en[g] && !source[g] && submode[g] && a_clk_i[g] && !a_prv[g] && !b_dir_i[g]
      && !zero_now[g] && count[g] == '0 |=> count[g] == '1)
      else $error("count did not wrap below zero");
  end

  bus_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && wb_ack_o |=> !wb_ack_o)
    else $error("ack held for two cycles");

endmodule : dqpc_top

`default_nettype wire

// ### tb/dqpc_src_model.sv
// encoder and pulse source model driving the counter pins
`timescale 1ns/1ps
`default_nettype none
module dqpc_src_model (
  input  wire logic       clk_i,
  output logic      [1:0] a_o,
  output logic      [1:0] b_o,
  output logic      [1:0] cci_o
);
  logic [1:0] ph [2];
  initial begin
    a_o = 2'h0;
    b_o = 2'h0;
    cci_o = 2'h0;
  end
  // pins back to phase zero so quadrature starts clean
  task automatic park;
    ph[0] = 2'h0;
    ph[1] = 2'h0;
    a_o <= 2'h0;
    b_o <= 2'h0;
    repeat (2) @(posedge clk_i);
  endtask : park
  task automatic pulse(input int i, input logic up);
    b_o[i] <= up;
    @(posedge clk_i);
    a_o[i] <= 1'b1;
    repeat (2) @(posedge clk_i);
    a_o[i] <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask : pulse
  // one gray step, levels held two clocks
  task automatic quad(input int i, input logic up);
    ph[i] = up ? ph[i] + 2'h1 : ph[i] - 2'h1;
    a_o[i] <= ph[i][1];
    b_o[i] <= ph[i][1] ^ ph[i][0];
    repeat (2) @(posedge clk_i);
  endtask : quad
  task automatic cci(input int i, input logic v);
    cci_o[i] <= v;
    @(posedge clk_i);
  endtask : cci
endmodule : dqpc_src_model
`default_nettype wire

// ### tb/tb.sv
// self-checking bench for the dual quadrature pulse counter
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk;
  logic        rst;
  logic        ce;
  logic        cyc;
  logic        we;
  logic [31:0] adr;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        ack;
  logic [1:0]  a;
  logic [1:0]  b;
  logic [1:0]  cc;
  logic [31:0] r;
  int          fail_count;
  int          tests_run;

  dqpc_src_model enc (.clk_i(clk), .a_o(a), .b_o(b), .cci_o(cc));
  dqpc_top DUT (.clk_i(clk), .rst_i(rst), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .a_clk_i(a), .b_dir_i(b), .clear_capture_input_i(cc));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // request held until ack is sampled, then released for a cycle
  task automatic xfer(input logic w, input logic [31:0] ad, input logic [31:0] d);
    cyc <= 1'b1;
    we <= w;
    adr <= ad;
    wdat <= d;
    // no local limit: a missing ack is left to the watchdog
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    @(posedge clk);
  endtask : xfer
  task automatic rd(input string nm, input logic [31:0] ad, input logic [31:0] e);
    xfer(1'b0, ad, 32'h0000_0000);
    chk(nm, r, e);
  endtask : rd
  task automatic counts(input logic [31:0] e1, input logic [31:0] e2);
    xfer(1'b1, dqpc_pkg::ADR_CAPTURE_CMD, 32'h0000_0003);
    rd("count1", dqpc_pkg::ADR_C1_CAP_RISE, e1);
    rd("count2", dqpc_pkg::ADR_C2_CAP_RISE, e2);
  endtask : counts
  task automatic setup(input logic [1:0] src, input logic [1:0] sub, input logic [1:0] role, input logic [1:0] en);
    xfer(1'b1, dqpc_pkg::ADR_RUN_CTRL, 32'h0000_0000);
    xfer(1'b1, dqpc_pkg::ADR_CLK_SOURCE, {30'h0, src});
    xfer(1'b1, dqpc_pkg::ADR_SUBMODE, {30'h0, sub});
    xfer(1'b1, dqpc_pkg::ADR_INPUT_ROLE, {30'h0, role});
    xfer(1'b1, dqpc_pkg::ADR_ZERO_CMD, 32'h0000_0003);
    xfer(1'b1, dqpc_pkg::ADR_RUN_CTRL, {30'h0, en});
  endtask : setup

  task automatic t_reset;
    logic [31:0] ads [11] = '{dqpc_pkg::ADR_RUN_CTRL, dqpc_pkg::ADR_INPUT_ROLE, dqpc_pkg::ADR_CLK_SOURCE,
      dqpc_pkg::ADR_SUBMODE, dqpc_pkg::ADR_ZERO_CMD, dqpc_pkg::ADR_CAPTURE_CMD, dqpc_pkg::ADR_C1_CAP_RISE,
      dqpc_pkg::ADR_C1_CAP_FALL, dqpc_pkg::ADR_C2_CAP_RISE, dqpc_pkg::ADR_C2_CAP_FALL, 32'h2040_0400};
    foreach (ads[i]) rd("reset", ads[i], 32'h0000_0000);
    rd("gate", dqpc_pkg::ADR_ZERO_GATE, 32'h0000_0003);
    $display("test reset done");
  endtask : t_reset

  task automatic t_clkdir;
    setup(2'h0, 2'h3, 2'h0, 2'h3);
    repeat (5) enc.pulse(0, 1'b1);
    repeat (3) enc.pulse(1, 1'b0);
    counts(32'h0000_0005, 32'hFFFF_FFFD);
    rd("status1", dqpc_pkg::ADR_C1_STATUS, 32'h0000_0003);
    xfer(1'b1, dqpc_pkg::ADR_RUN_CTRL, 32'h0000_0001);
    rd("run", dqpc_pkg::ADR_RUN_CTRL, 32'h0000_0001);
    enc.pulse(0, 1'b1);
    enc.pulse(1, 1'b1);
    counts(32'h0000_0006, 32'hFFFF_FFFD);
    xfer(1'b1, dqpc_pkg::ADR_ZERO_CMD, 32'h0000_0001);
    counts(32'h0000_0000, 32'hFFFF_FFFD);
    rd("zcmd", dqpc_pkg::ADR_ZERO_CMD, 32'h0000_0000);
    xfer(1'b1, dqpc_pkg::ADR_ZERO_CMD, 32'h0000_0002);
    counts(32'h0000_0000, 32'h0000_0000);
    // a pulse seen only while the clock enable is low must not count
    ce <= 1'b0;
    enc.pulse(0, 1'b1);
    ce <= 1'b1;
    counts(32'h0000_0000, 32'h0000_0000);
    $display("test clkdir done");
  endtask : t_clkdir

  task automatic t_quad;
    enc.park();
    setup(2'h0, 2'h0, 2'h0, 2'h3);
    repeat (4) enc.quad(0, 1'b1);
    repeat (2) enc.quad(0, 1'b0);
    repeat (3) enc.quad(1, 1'b0);
    counts(32'h0000_0002, 32'hFFFF_FFFD);
    $display("test quad done");
  endtask : t_quad

  task automatic t_input;
    // the quadrature test leaves A high, which would swallow the first rising edge
    enc.park();
    setup(2'h0, 2'h3, 2'h3, 2'h3);
    repeat (3) enc.pulse(0, 1'b1);
    enc.cci(0, 1'b1);
    enc.cci(0, 1'b0);
    repeat (2) @(posedge clk);
    rd("cap", dqpc_pkg::ADR_C1_CAP_RISE, 32'h0000_0003);
    enc.pulse(0, 1'b1);
    enc.cci(0, 1'b1);
    enc.cci(0, 1'b0);
    repeat (2) @(posedge clk);
    rd("recap", dqpc_pkg::ADR_C1_CAP_RISE, 32'h0000_0004);
    xfer(1'b1, dqpc_pkg::ADR_INPUT_ROLE, 32'h0000_0000);
    enc.cci(0, 1'b1);
    enc.cci(0, 1'b0);
    counts(32'h0000_0000, 32'h0000_0000);
    $display("test input done");
  endtask : t_input

  // 250 clocks span exactly 20 fast or 5 slow reference ticks
  task automatic t_meas(input logic [1:0] sub, input logic [31:0] e);
    logic [31:0] r1;
    setup(2'h1, sub, 2'h1, 2'h1);
    enc.cci(0, 1'b1);
    repeat (249) @(posedge clk);
    enc.cci(0, 1'b0);
    repeat (2) @(posedge clk);
    xfer(1'b0, dqpc_pkg::ADR_C1_CAP_RISE, 32'h0000_0000);
    r1 = r;
    xfer(1'b0, dqpc_pkg::ADR_C1_CAP_FALL, 32'h0000_0000);
    chk("period", r - r1, e);
    $display("test meas done");
  endtask : t_meas

  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    close_out();
  end
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    cyc = 1'b0;
    we = 1'b0;
    adr = 32'h0000_0000;
    wdat = 32'h0000_0000;
    fail_count = 0;
    tests_run = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_clkdir();
    t_quad();
    t_input();
    t_meas(2'h0, 32'h0000_0014);
    t_meas(2'h1, 32'h0000_0005);
    close_out();
  end
endmodule : tb
`default_nettype wire
